/* verilog/fbg_top.sv */
// flash boot error reporting and programming guard logic
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`include "fbg_map.svh"

// What this block does
// - setup faults reported as codes 21..27
// - flash blocked after operation until key cleared
// - nonblank key area reads zero in programmer
// - watchdog frozen while routine downloads
// - inquiry error byte zero normal, one error
module fbg_top #(
    parameter int DL_CYCLES = `FBG_DL_CYCLES
) (
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire logic [`FBG_ADDR_W-1:0]     reg_addr,
    input  wire logic [`FBG_DATA_W-1:0]     reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    input  wire logic                       reg_from_dma,
    output fbg_pkg::fbg_byte_t              reg_rdata,
    input  wire logic                       err_devid,
    input  wire logic                       err_clkmode,
    input  wire logic                       err_bitrate,
    input  wire logic                       err_infreq,
    input  wire logic                       err_mult,
    input  wire logic                       err_opfreq,
    input  wire logic                       err_sum,
    input  wire logic                       err_cmd,
    input  wire logic                       err_clear,
    input  wire logic [7:0]                 boot_state,
    output fbg_pkg::fbg_byte_t              err_code,
    output logic                            err_status,
    output fbg_pkg::fbg_byte_t              inquiry_state,
    input  wire logic                       op_done,
    output logic                            flash_access_en,
    input  wire logic                       arr_wr,
    input  wire logic [23:0]                arr_wr_addr,
    input  wire logic [7:0]                 arr_wr_data,
    input  wire logic                       arr_erase_key_blk,
    input  wire logic                       prog_mode_pin,
    input  wire logic                       arr_rd_valid,
    input  wire logic [7:0]                 arr_rd_data,
    output fbg_pkg::fbg_byte_t              prog_rd_data,
    output logic                            prog_rd_valid,
    output logic                            download_busy,
    output logic                            array_sel,
    input  wire logic                       wdt_tick_in,
    output logic                            wdt_tick,
    output logic                            irq
);
    import fbg_pkg::*;

    typedef struct packed {
        logic                   dlreq;
        fbg_dl_t                dl;
        fbg_byte_t              key;
        fbg_byte_t              arrsel;
        fbg_byte_t              errcode;
        logic                   errflag;
        fbg_byte_t              state;
        logic                   acc_open;
        logic [3:0]             keynff;
        logic [`FBG_IRQ_W-1:0]  irqstat;
        logic [`FBG_IRQ_W-1:0]  irqen;
        fbg_byte_t              rdata;
        fbg_byte_t              prdata;
        logic                   prvalid;
        logic                   wdt;
        logic                   irq;
    } fbg_state_t;

    localparam int CW = $clog2(DL_CYCLES + 1);

    fbg_state_t r;
    fbg_state_t next_r;
    logic       prog_mode;
    logic       dl_load;
    logic       dl_busy;
    logic       dl_done;
    logic       wr_ok;
    logic       dma_rej;
    logic       any_err;
    fbg_byte_t  new_code;
    logic [`FBG_IRQ_W-1:0] ev;

    fbg_sync3 u_sync (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (prog_mode_pin),
        .level (prog_mode)
    );

    fbg_count #(
        .W (CW)
    ) u_dl (
        .clk      (clk),
        .nrst     (nrst),
        .load     (dl_load),
        .load_val (CW'(DL_CYCLES)),
        .busy     (dl_busy),
        .done     (dl_done)
    );

    // control writes from the dma controller are dropped and flagged
    // dma reads stay allowed; only its writes could do harm
    assign wr_ok   = reg_wr & ~reg_from_dma;
    assign dma_rej = reg_wr & reg_from_dma;
    // a new request while idle starts the routine download
    assign dl_load = wr_ok && reg_addr == `FBG_OFF_CTRL
                     && reg_wdata[`FBG_CTRL_DLREQ]
                     && r.dl == FBG_DL_IDLE;

    // highest priority goes to the earliest setup stage
    always_comb begin
        any_err  = 1'b1;
        new_code = `FBG_ERR_NONE;
        if (err_devid) begin
            new_code = `FBG_ERR_DEVID;
        end else if (err_clkmode) begin
            new_code = `FBG_ERR_CLKMODE;
        end else if (err_bitrate) begin
            new_code = `FBG_ERR_BITRATE;
        end else if (err_infreq) begin
            new_code = `FBG_ERR_INFREQ;
        end else if (err_mult) begin
            new_code = `FBG_ERR_MULT;
        end else if (err_opfreq) begin
            new_code = `FBG_ERR_OPFREQ;
        end else if (err_sum) begin
            new_code = `FBG_ERR_SUM;
        end else if (err_cmd) begin
            new_code = `FBG_ERR_CMD;
        end else begin
            any_err = 1'b0;
        end
    end

    always_comb begin
        ev = '0;
        ev[`FBG_IRQ_OPDONE] = op_done;
        ev[`FBG_IRQ_ERROR]  = any_err;
        ev[`FBG_IRQ_DLDONE] = dl_done;
        ev[`FBG_IRQ_DMAREJ] = dma_rej;
    end

    always_comb begin
        next_r         = r;
        next_r.rdata   = 8'h00;
        next_r.prvalid = 1'b0;
        next_r.state   = boot_state;

        // register writes
        if (wr_ok) begin
            case (reg_addr)
                `FBG_OFF_CTRL: begin
                    if (!reg_wdata[`FBG_CTRL_DLREQ] && !dl_busy) begin
                        next_r.dlreq = 1'b0;
                    end
                end
                `FBG_OFF_KEY: begin
                    next_r.key = reg_wdata;
                    // clearing the key reopens the arrays
                    if (reg_wdata == 8'h00) begin
                        next_r.acc_open = 1'b1;
                    end
                end
                `FBG_OFF_ARRSEL: next_r.arrsel = reg_wdata;
                `FBG_OFF_ERRSTAT: begin
                    next_r.errflag = 1'b0;
                    next_r.errcode = `FBG_ERR_NONE;
                end
                `FBG_OFF_IRQEN: next_r.irqen = reg_wdata[`FBG_IRQ_W-1:0];
                `FBG_OFF_IRQCLR: begin
                    next_r.irqstat = r.irqstat
                                     & ~reg_wdata[`FBG_IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (err_clear) begin
            next_r.errflag = 1'b0;
            next_r.errcode = `FBG_ERR_NONE;
        end

        // download sequencer
        case (r.dl)
            FBG_DL_IDLE: begin
                if (dl_load) begin
                    next_r.dlreq = 1'b1;
                    next_r.dl    = FBG_DL_LOADING;
                end
            end
            FBG_DL_LOADING: begin
                if (dl_done) begin
                    next_r.dlreq = 1'b0;
                    next_r.dl    = FBG_DL_IDLE;
                end
            end
            default: begin
                next_r.dl    = FBG_DL_IDLE;
                next_r.dlreq = 1'b0;
            end
        endcase

        // set wins over any clear in the same cycle
        if (op_done) begin
            next_r.acc_open = 1'b0;
        end
        if (any_err) begin
            next_r.errcode = new_code;
            next_r.errflag = 1'b1;
        end

        // key code area shadow: any non-blank byte locks reads
        if (arr_wr && arr_wr_addr >= `FBG_KEY_LO
            && arr_wr_addr <= `FBG_KEY_HI) begin
            if (arr_wr_data != `FBG_BLANK) begin
                next_r.keynff[arr_wr_addr[1:0]] = 1'b1;
            end
        end
        if (arr_erase_key_blk) begin
            next_r.keynff = 4'h0;
        end

        // programmer-mode read path, one cycle latency
        // the pin is sync-late: a read just after entry is not yet locked
        if (arr_rd_valid) begin
            next_r.prvalid = 1'b1;
            if (prog_mode && r.keynff != 4'h0) begin
                next_r.prdata = `FBG_LOCKED_DATA;
            end else begin
                next_r.prdata = arr_rd_data;
            end
        end

        // watchdog count enable is cut while the routine loads
        // the tick lags a cycle, so the cut shows one cycle after the request
        next_r.wdt = wdt_tick_in
                     & ~(r.dlreq & (r.dl == FBG_DL_LOADING));

        // events: hardware set beats software clear
        next_r.irqstat = next_r.irqstat | ev;
        next_r.irq     = |(next_r.irqstat & next_r.irqen);

        // read data appears in the cycle after the strobe only
        if (reg_rd) begin
            case (reg_addr)
                `FBG_OFF_CTRL: next_r.rdata = {7'h00, r.dlreq};
                `FBG_OFF_KEY: next_r.rdata = r.key;
                `FBG_OFF_ARRSEL: next_r.rdata = r.arrsel;
                `FBG_OFF_ERRCODE: next_r.rdata = r.errcode;
                `FBG_OFF_ERRSTAT: next_r.rdata = {7'h00, r.errflag};
                `FBG_OFF_STATE: next_r.rdata = r.state;
                `FBG_OFF_IRQSTAT: begin
                    next_r.rdata = {{(8-`FBG_IRQ_W){1'b0}}, r.irqstat};
                end
                `FBG_OFF_IRQEN: begin
                    next_r.rdata = {{(8-`FBG_IRQ_W){1'b0}}, r.irqen};
                end
                `FBG_OFF_GUARD: begin
                    next_r.rdata = {5'h00,
                                    r.dl == FBG_DL_LOADING,
                                    r.keynff != 4'h0,
                                    !r.acc_open};
                end
                default: next_r.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r         <= '0;
            r.dl      <= FBG_DL_IDLE;
            r.key     <= `FBG_RST_KEY;
            r.arrsel  <= `FBG_RST_ARRSEL;
            r.irqen   <= `FBG_RST_IRQEN;
            r.errcode <= `FBG_ERR_NONE;
            // arrays start open; a finished operation closes them
            r.acc_open <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata       = r.rdata;
    assign err_code        = r.errcode;
    assign err_status      = r.errflag;
    assign inquiry_state   = r.state;
    assign flash_access_en = r.acc_open;
    assign prog_rd_data    = r.prdata;
    assign prog_rd_valid   = r.prvalid;
    assign download_busy   = r.dlreq;
    assign array_sel       = r.arrsel[0];
    assign wdt_tick        = r.wdt;
    assign irq             = r.irq;
endmodule

/* verilog/fbg_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef FBG_MAP_SVH
`define FBG_MAP_SVH

`define FBG_ADDR_W          4
`define FBG_DATA_W          8

`define FBG_OFF_CTRL        4'h0
`define FBG_OFF_KEY         4'h1
`define FBG_OFF_ARRSEL      4'h2
`define FBG_OFF_ERRCODE     4'h3
`define FBG_OFF_ERRSTAT     4'h4
`define FBG_OFF_STATE       4'h5
`define FBG_OFF_IRQSTAT     4'h6
`define FBG_OFF_IRQEN       4'h7
`define FBG_OFF_IRQCLR      4'h8
`define FBG_OFF_GUARD       4'h9

`define FBG_CTRL_DLREQ      0
`define FBG_GUARD_BLOCKED   0
`define FBG_GUARD_KEYLOCK   1
`define FBG_GUARD_LOADING   2

`define FBG_IRQ_OPDONE      0
`define FBG_IRQ_ERROR       1
`define FBG_IRQ_DLDONE      2
`define FBG_IRQ_DMAREJ      3
`define FBG_IRQ_W           4

`define FBG_RST_KEY         8'h00
`define FBG_RST_ARRSEL      8'h00
`define FBG_RST_IRQEN       4'h0

`define FBG_ERR_NONE        8'h00
`define FBG_ERR_SUM         8'h11
`define FBG_ERR_DEVID       8'h21
`define FBG_ERR_CLKMODE     8'h22
`define FBG_ERR_BITRATE     8'h24
`define FBG_ERR_INFREQ      8'h25
`define FBG_ERR_MULT        8'h26
`define FBG_ERR_OPFREQ      8'h27
`define FBG_ERR_CMD         8'h80

`define FBG_KEY_LO          24'h00003c
`define FBG_KEY_HI          24'h00003f
`define FBG_BLANK           8'hff
`define FBG_LOCKED_DATA     8'h00

`define FBG_CLK_MHZ         20
`define FBG_DL_TIME_US      600
`define FBG_DL_CYCLES       (`FBG_DL_TIME_US * `FBG_CLK_MHZ)

`endif

/* verilog/fbg_pkg.sv */
// types shared by the flash boot error and guard block
package fbg_pkg;

    typedef enum logic [1:0] {
        FBG_DL_IDLE    = 2'b01,
        FBG_DL_LOADING = 2'b10
    } fbg_dl_t;

    typedef logic [7:0] fbg_byte_t;

endpackage

/* verilog/fbg_sync3.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module fbg_sync3 (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic pin,
    output logic      level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } fbg_sync_t;

    fbg_sync_t r;
    fbg_sync_t next_r;

    always_comb begin
        next_r    = r;
        next_r.s1 = pin;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        // only stages two and three vote; stage one stays private
        if (r.s2 == r.s3) begin
            next_r.lvl = r.s3;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign level = r.lvl;
endmodule

/* verilog/fbg_count.sv */
// loadable down counter with a one-cycle done pulse
`timescale 1ns/10ps
module fbg_count #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              busy,
    output logic              done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         busy;
        logic         done;
    } fbg_cnt_t;

    fbg_cnt_t r;
    fbg_cnt_t next_r;

    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        if (load) begin
            next_r.cnt  = load_val;
            next_r.busy = 1'b1;
        end else if (r.busy) begin
            if (r.cnt <= W'(1)) begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
                next_r.cnt  = '0;
            end else begin
                next_r.cnt = r.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign busy = r.busy;
    assign done = r.done;
endmodule

/* verif/fbg_top_properties.sv */
// assertion checker bound to the flash guard top
`timescale 1ns/10ps
`include "fbg_map.svh"
module fbg_top_properties import fbg_pkg::*; #(
    parameter int DL_CYCLES = 20
) (
    input wire logic               clk,
    input wire logic               nrst,
    input wire logic [3:0]         reg_addr,
    input wire logic [7:0]         reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_from_dma,
    input wire logic               err_devid,
    input wire logic               err_clkmode,
    input wire logic               err_bitrate,
    input wire logic               err_infreq,
    input wire logic               err_mult,
    input wire logic               err_opfreq,
    input wire logic               err_sum,
    input wire logic               err_cmd,
    input wire logic               err_clear,
    input wire fbg_pkg::fbg_byte_t err_code,
    input wire logic               err_status,
    input wire logic               op_done,
    input wire logic               flash_access_en,
    input wire logic               arr_wr,
    input wire logic [23:0]        arr_wr_addr,
    input wire logic [7:0]         arr_wr_data,
    input wire logic               arr_erase_key_blk,
    input wire logic               prog_mode_pin,
    input wire logic               arr_rd_valid,
    input wire logic [7:0]         arr_rd_data,
    input wire fbg_pkg::fbg_byte_t prog_rd_data,
    input wire logic               prog_rd_valid,
    input wire logic               download_busy,
    input wire logic               wdt_tick
);
    logic        any_err;
    fbg_byte_t   exp_code;
    logic        key_wr;
    logic        key_lk;
    int unsigned run_n;
    assign any_err = err_devid | err_clkmode | err_bitrate | err_infreq
                   | err_mult | err_opfreq | err_sum | err_cmd;
    assign exp_code = err_devid   ? `FBG_ERR_DEVID   :
                      err_clkmode ? `FBG_ERR_CLKMODE :
                      err_bitrate ? `FBG_ERR_BITRATE :
                      err_infreq  ? `FBG_ERR_INFREQ  :
                      err_mult    ? `FBG_ERR_MULT    :
                      err_opfreq  ? `FBG_ERR_OPFREQ  :
                      err_sum     ? `FBG_ERR_SUM     : `FBG_ERR_CMD;
    assign key_wr = arr_wr && arr_wr_addr >= `FBG_KEY_LO
                 && arr_wr_addr <= `FBG_KEY_HI && arr_wr_data != `FBG_BLANK;
    // erase beats a key write in the same cycle, as in the design
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            key_lk <= 1'b0;
            run_n  <= 0;
        end else begin
            run_n  <= download_busy ? run_n + 1 : 0;
            key_lk <= arr_erase_key_blk ? 1'b0 : (key_wr | key_lk);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence dl_req;
        reg_wr && !reg_from_dma && reg_addr == `FBG_OFF_CTRL
        && reg_wdata[`FBG_CTRL_DLREQ] && !download_busy;
    endsequence
    sequence dl_end;
        download_busy ##1 !download_busy;
    endsequence
    prio_code_a: assert property (
        any_err |=> err_code == $past(exp_code))
        else $error("wrong error code");
    err_flag_a: assert property (any_err |=> err_status)
        else $error("error flag not set");
    err_clear_a: assert property (
        err_clear && !any_err |=> !err_status
        && err_code == `FBG_ERR_NONE) else $error("clear failed");
    lock_close_a: assert property (op_done |=> !flash_access_en)
        else $error("flash open after operation");
    lock_cause_a: assert property (
        $fell(flash_access_en) |-> $past(op_done))
        else $error("flash closed without operation");
    key_read_a: assert property (
        arr_rd_valid && key_lk && prog_mode_pin && $past(prog_mode_pin, 6)
        |=> prog_rd_valid && prog_rd_data == 8'h00)
        else $error("locked key area read out");
    open_pass_a: assert property (
        arr_rd_valid && !key_lk |=> prog_rd_valid
        && prog_rd_data == $past(arr_rd_data)) else $error("read data lost");
    dl_start_a: assert property (dl_req |=> download_busy)
        else $error("download did not start");
    dl_len_a: assert property (dl_end |-> run_n == DL_CYCLES + 1)
        else $error("download length wrong");
    wdt_hold_a: assert property (
        download_busy && $past(download_busy) |-> !wdt_tick)
        else $error("watchdog counted during download");
    dma_drop_a: assert property (
        reg_wr && reg_from_dma && !download_busy |=> !download_busy)
        else $error("dma write started download");
endmodule

bind fbg_top fbg_top_properties #(.DL_CYCLES(DL_CYCLES)) chk_u (
    .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_from_dma, .err_devid,
    .err_clkmode, .err_bitrate, .err_infreq, .err_mult, .err_opfreq,
    .err_sum, .err_cmd, .err_clear, .err_code, .err_status, .op_done,
    .flash_access_en, .arr_wr, .arr_wr_addr, .arr_wr_data,
    .arr_erase_key_blk, .prog_mode_pin, .arr_rd_valid, .arr_rd_data,
    .prog_rd_data, .prog_rd_valid, .download_busy, .wdt_tick
);

/* verif/fbg_host_model.sv */
// host programmer and flash array model on the boot link
`timescale 1ns/10ps
module fbg_host_model (
    input  wire logic  clk,
    output logic       arr_wr,
    output logic [23:0] arr_wr_addr,
    output logic [7:0] arr_wr_data,
    output logic       arr_erase_key_blk,
    output logic       arr_rd_valid,
    output logic [7:0] arr_rd_data
);
    logic [7:0] mem [0:127];
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = 8'hff;
        arr_wr = 1'b0;
        arr_wr_addr = 24'h0;
        arr_wr_data = 8'h5a;
        arr_erase_key_blk = 1'b0;
        arr_rd_valid = 1'b0;
        arr_rd_data = 8'ha5;
    end
    // only erased bytes, key area or above the vectors; others skipped
    task automatic prog(input logic [6:0] a, input logic [7:0] d);
        if (mem[a] == 8'hff && a >= 7'h3c) begin
            @(posedge clk);
            arr_wr <= 1'b1;
            arr_wr_addr <= {17'h0, a};
            arr_wr_data <= d;
            @(posedge clk);
            arr_wr <= 1'b0;
            arr_wr_data <= ~d;
            mem[a] = d;
        end
    endtask
    task automatic erase_key();
        @(posedge clk);
        arr_erase_key_blk <= 1'b1;
        @(posedge clk);
        arr_erase_key_blk <= 1'b0;
        for (int i = 8'h3c; i < 8'h40; i++) mem[i] = 8'hff;
    endtask
    // released data line shows the inverse so stale values never match
    task automatic fetch(input logic [6:0] a);
        @(posedge clk);
        arr_rd_valid <= 1'b1;
        arr_rd_data <= mem[a];
        @(posedge clk);
        arr_rd_valid <= 1'b0;
        arr_rd_data <= ~mem[a];
    endtask
endmodule

/* verif/testbench.sv */
// self-checking bench for the flash guard top
`timescale 1ns/10ps
`include "fbg_map.svh"
module testbench;
    import fbg_pkg::*;
    localparam int DLC = 20;
    localparam fbg_byte_t CODES [8] = '{`FBG_ERR_DEVID, `FBG_ERR_CLKMODE,
        `FBG_ERR_BITRATE, `FBG_ERR_INFREQ, `FBG_ERR_MULT, `FBG_ERR_OPFREQ,
        `FBG_ERR_SUM, `FBG_ERR_CMD};
    logic clk, nrst, reg_wr, reg_rd, reg_from_dma, err_clear, op_done;
    logic prog_mode_pin, wdt_tick_in, err_status, flash_access_en;
    logic prog_rd_valid, download_busy, array_sel, wdt_tick, irq;
    logic arr_wr, arr_erase_key_blk, arr_rd_valid;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, e, boot_state, arr_wr_data, arr_rd_data;
    logic [23:0] arr_wr_addr;
    fbg_byte_t reg_rdata, err_code, inquiry_state, prog_rd_data;
    int failures, checks_done, cycles, n;
    fbg_host_model host_u (.clk, .arr_wr, .arr_wr_addr, .arr_wr_data,
        .arr_erase_key_blk, .arr_rd_valid, .arr_rd_data);
    fbg_top #(.DL_CYCLES(DLC)) dut_u (.clk, .nrst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_from_dma, .reg_rdata, .err_devid(e[0]),
        .err_clkmode(e[1]), .err_bitrate(e[2]), .err_infreq(e[3]),
        .err_mult(e[4]), .err_opfreq(e[5]), .err_sum(e[6]), .err_cmd(e[7]),
        .err_clear, .boot_state, .err_code, .err_status, .inquiry_state,
        .op_done, .flash_access_en, .arr_wr, .arr_wr_addr, .arr_wr_data,
        .arr_erase_key_blk, .prog_mode_pin, .arr_rd_valid, .arr_rd_data,
        .prog_rd_data, .prog_rd_valid, .download_busy, .array_sel,
        .wdt_tick_in, .wdt_tick, .irq);
    task report_and_stop();
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task chk(input logic [7:0] s, input logic [7:0] x);
        checks_done++;
        if (s !== x) begin
            failures++;
            $display("BAD %0t saw %h want %h", $time, s, x);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] x);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, x);
    endtask
    // one-cycle pulse on the named strobe vector, then let it land
    task pulse(input logic [7:0] v, input logic c, input logic o);
        @(posedge clk);
        e <= v;
        err_clear <= c;
        op_done <= o;
        @(posedge clk);
        e <= 8'h0;
        err_clear <= 1'b0;
        op_done <= 1'b0;
        #1;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        {nrst, reg_wr, reg_rd, reg_from_dma, err_clear, op_done} = 6'h0;
        {prog_mode_pin, wdt_tick_in, reg_addr, reg_wdata, e} = 22'h0;
        boot_state = 8'h11;
        {failures, checks_done, cycles} = '0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd(`FBG_OFF_KEY, `FBG_RST_KEY);
        rd(`FBG_OFF_ARRSEL, `FBG_RST_ARRSEL);
        rd(`FBG_OFF_IRQEN, {4'h0, `FBG_RST_IRQEN});
        rd(4'hf, 8'h00);
        for (int i = 0; i < 8; i++) begin
            pulse(8'h1 << i, 1'b0, 1'b0);
            chk(err_code, CODES[i]);
            chk(8'(err_status), 8'h1);
            pulse(8'h0, 1'b1, 1'b0);
            chk(err_code, `FBG_ERR_NONE);
        end
        pulse(8'h81, 1'b0, 1'b0);
        rd(`FBG_OFF_ERRCODE, `FBG_ERR_DEVID);
        wr(`FBG_OFF_IRQEN, 8'h02);
        rd(`FBG_OFF_IRQSTAT, 8'h02);
        chk(8'(irq), 8'h1);
        wr(`FBG_OFF_IRQEN, 8'h00);
        rd(`FBG_OFF_ERRSTAT, 8'h01);
        chk(8'(irq), 8'h0);
        wr(`FBG_OFF_IRQCLR, 8'h02);
        wr(`FBG_OFF_ERRSTAT, 8'h00);
        rd(`FBG_OFF_IRQSTAT, 8'h00);
        chk(err_code, `FBG_ERR_NONE);
        @(posedge clk) boot_state <= 8'h1f;
        rd(`FBG_OFF_STATE, 8'h1f);
        chk(inquiry_state, 8'h1f);
        @(posedge clk) wdt_tick_in <= 1'b1;
        wr(`FBG_OFF_CTRL, 8'h01);
        chk(8'(download_busy), 8'h1);
        @(posedge clk);
        #1 chk(8'(wdt_tick), 8'h0);
        n = 2;
        while (download_busy === 1'b1 && n < 100) begin
            @(posedge clk);
            #1 n += download_busy;
        end
        chk(8'(n), 8'(DLC + 1));
        @(posedge clk);
        #1 chk(8'(wdt_tick), 8'h1);
        rd(`FBG_OFF_IRQSTAT, 8'h04);
        wr(`FBG_OFF_IRQCLR, 8'h04);
        @(posedge clk) reg_from_dma <= 1'b1;
        wr(`FBG_OFF_CTRL, 8'h01);
        chk(8'(download_busy), 8'h0);
        wr(`FBG_OFF_ARRSEL, 8'h01);
        chk(8'(array_sel), 8'h0);
        @(posedge clk) reg_from_dma <= 1'b0;
        rd(`FBG_OFF_IRQSTAT, 8'h08);
        wr(`FBG_OFF_ARRSEL, 8'h01);
        chk(8'(array_sel), 8'h1);
        pulse(8'h0, 1'b0, 1'b1);
        chk(8'(flash_access_en), 8'h0);
        rd(`FBG_OFF_GUARD, 8'h01);
        wr(`FBG_OFF_KEY, 8'h5a);
        chk(8'(flash_access_en), 8'h0);
        wr(`FBG_OFF_KEY, 8'h00);
        chk(8'(flash_access_en), 8'h1);
        @(posedge clk) prog_mode_pin <= 1'b1;
        repeat (8) @(posedge clk);
        host_u.fetch(7'h3c);
        #1 chk(prog_rd_data, 8'hff);
        host_u.prog(7'h3d, 8'h12);
        host_u.prog(7'h50, 8'ha5);
        host_u.fetch(7'h50);
        #1 chk(prog_rd_data, 8'h00);
        chk(8'(prog_rd_valid), 8'h1);
        rd(`FBG_OFF_GUARD, 8'h02);
        host_u.erase_key();
        host_u.fetch(7'h50);
        #1 chk(prog_rd_data, 8'ha5);
        pulse(8'h0, 1'b0, 1'b1);
        @(posedge clk) nrst <= 1'b0;
        repeat (2001) @(posedge clk);
        nrst <= 1'b1;
        #1 chk(8'(flash_access_en), 8'h1);
        chk(err_code, `FBG_ERR_NONE);
        report_and_stop();
    end
endmodule
